// ==== io_crossbar_pkg.sv ====
// Constants for the port crossbar: register address, bit fields,
// crossbar signal order and pin layout.
// Assumes a byte-wide special-register port in the system clock domain.
`default_nettype none
package io_crossbar_pkg;
  // Crossbar enable register
  localparam logic [7:0] ROUTE_EN0_ADDR  = 8'hE1;
  localparam logic [5:0] ROUTE_EN0_RESET = 6'h00;
  localparam int ROUTE_EN0_BITS          = 6;
  localparam int SERIAL_PORT_ROUTE_BIT   = 0;
  localparam int SPI_ROUTE_BIT           = 1;
  localparam int TWOWIRE_ROUTE_BIT       = 2;
  localparam int SYSCLK_OUT_ROUTE_BIT    = 3;
  localparam int COMPARATOR_OUT_BIT      = 4;
  localparam int ASYNC_COMPARATOR_BIT    = 5;

  // Crossbar signals in priority order
  localparam int NUM_SIG          = 14;
  localparam int IDX_SERIAL_TX    = 0;
  localparam int IDX_SERIAL_RX    = 1;
  localparam int IDX_SPI_SCK      = 2;
  localparam int IDX_SPI_MISO     = 3;
  localparam int IDX_SPI_MOSI     = 4;
  localparam int IDX_SPI_SEL      = 5;
  localparam int IDX_TWOWIRE_DATA = 6;
  localparam int IDX_TWOWIRE_CLK  = 7;
  localparam int IDX_COMPARATOR   = 8;
  localparam int IDX_ASYNC_COMP   = 9;
  localparam int IDX_SYSCLK_OUT   = 10;
  localparam int IDX_COMPARE_A    = 11;
  localparam int IDX_COMPARE_B    = 12;
  localparam int IDX_COMPARE_C    = 13;

  // Pins: port 0 pins 0..7, then port 1 pins 0..7
  localparam int NUM_PIN                = 16;
  localparam logic [3:0] SERIAL_TX_PIN  = 4'h4;
  localparam logic [3:0] SERIAL_RX_PIN  = 4'h5;
  localparam logic [15:0] PIN_PRESENT_DEFAULT = 16'h0FFF;
  localparam logic [13:0] SIG_RESET     = 14'h0000;
  localparam logic [15:0] PIN_RESET     = 16'h0000;
  localparam logic [13:0] SIG_IN_RESET  = 14'h3FFF;
endpackage
`default_nettype wire

// ==== io_crossbar_routing.sv ====
// Priority crossbar routing peripheral signals onto port 0 and port 1.
// Assumes peripherals, register port and pins share clk; pins are
// synchronous; skip masks and the second crossbar fields arrive as inputs.
`timescale 1ns/100ps
`default_nettype none
module io_crossbar_routing
#(
  parameter logic [15:0] PIN_PRESENT = io_crossbar_pkg::PIN_PRESENT_DEFAULT
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        crossbar_enable,
  input  wire logic        spi_four_wire,
  input  wire logic [1:0]  compare_output_select,
  input  wire logic [7:0]  port0_pin_bypass,
  input  wire logic [7:0]  port1_pin_bypass,
  input  wire logic [13:0] sig_out,
  input  wire logic [13:0] sig_oe,
  output logic      [13:0] sig_in,
  input  wire logic [15:0] gpio_out,
  input  wire logic [15:0] gpio_oe,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  output logic      [15:0] pin_assigned
);
  import io_crossbar_pkg::*;

  logic [5:0]  route_en_reg;
  logic [5:0]  route_en_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [13:0] sig_valid_reg;
  logic [13:0] sig_valid_next;
  logic [3:0]  sig_pin_reg [NUM_SIG];
  logic [3:0]  sig_pin_next [NUM_SIG];
  logic [15:0] pin_own_reg;
  logic [15:0] pin_own_next;
  logic [3:0]  pin_owner_reg [NUM_PIN];
  logic [3:0]  pin_owner_next [NUM_PIN];
  logic [15:0] pin_out_reg;
  logic [15:0] pin_out_next;
  logic [15:0] pin_oe_reg;
  logic [15:0] pin_oe_next;
  logic [13:0] sig_in_reg;
  logic [13:0] sig_in_next;

  // Lowest set bit of a free-pin mask, with a found flag on top
  function automatic logic [4:0] first_free(input logic [15:0] avail);
    logic [4:0] r;
    r = 5'h00;
    for (int p = NUM_PIN - 1; p >= 0; p--)
    begin
      if (avail[p])
      begin
        r = {1'b1, 4'(p)};
      end
    end
    return r;
  endfunction

  // Register port
  always_comb
  begin
    route_en_next = route_en_reg;
    if (sfr_wr && sfr_addr == ROUTE_EN0_ADDR)
    begin
      route_en_next = sfr_wdata[ROUTE_EN0_BITS-1:0];
    end
    rdata_next = 8'h00;
    if (sfr_addr == ROUTE_EN0_ADDR)
    begin
      rdata_next = {2'b00, route_en_reg};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      route_en_reg <= ROUTE_EN0_RESET;
      rdata_reg    <= 8'h00;
    end
    else
    begin
      route_en_reg <= route_en_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;

  // Priority assignment of signals to pins
  always_comb
  begin
    logic [13:0] want;
    logic [15:0] used;
    logic [15:0] avail;
    logic [4:0]  hit;
    hit = 5'h00;
    want = 14'h0000;
    used = 16'h0000;
    avail = PIN_PRESENT & ~{port1_pin_bypass, port0_pin_bypass};
    sig_valid_next = 14'h0000;
    sig_pin_next = '{default: 4'h0};
    if (crossbar_enable)
    begin
      want[IDX_SERIAL_TX]    = route_en_reg[SERIAL_PORT_ROUTE_BIT];
      want[IDX_SERIAL_RX]    = route_en_reg[SERIAL_PORT_ROUTE_BIT];
      want[IDX_SPI_SCK]      = route_en_reg[SPI_ROUTE_BIT];
      want[IDX_SPI_MISO]     = route_en_reg[SPI_ROUTE_BIT];
      want[IDX_SPI_MOSI]     = route_en_reg[SPI_ROUTE_BIT];
      want[IDX_SPI_SEL]      = route_en_reg[SPI_ROUTE_BIT]
                               && spi_four_wire;
      want[IDX_TWOWIRE_DATA] = route_en_reg[TWOWIRE_ROUTE_BIT];
      want[IDX_TWOWIRE_CLK]  = route_en_reg[TWOWIRE_ROUTE_BIT];
      want[IDX_COMPARATOR]   = route_en_reg[COMPARATOR_OUT_BIT];
      want[IDX_ASYNC_COMP]   = route_en_reg[ASYNC_COMPARATOR_BIT];
      want[IDX_SYSCLK_OUT]   = route_en_reg[SYSCLK_OUT_ROUTE_BIT];
      want[IDX_COMPARE_A]    = compare_output_select != 2'b00;
      want[IDX_COMPARE_B]    = compare_output_select[1];
      want[IDX_COMPARE_C]    = compare_output_select == 2'b11;
    end
    // Serial port owns fixed pins ahead of the priority scan
    if (want[IDX_SERIAL_TX])
    begin
      sig_valid_next[IDX_SERIAL_TX] = PIN_PRESENT[SERIAL_TX_PIN];
      sig_valid_next[IDX_SERIAL_RX] = PIN_PRESENT[SERIAL_RX_PIN];
      sig_pin_next[IDX_SERIAL_TX] = SERIAL_TX_PIN;
      sig_pin_next[IDX_SERIAL_RX] = SERIAL_RX_PIN;
      used[SERIAL_TX_PIN] = 1'b1;
      used[SERIAL_RX_PIN] = 1'b1;
    end
    for (int k = IDX_SPI_SCK; k < NUM_SIG; k++)
    begin
      hit = first_free(avail & ~used);
      if (want[k] && hit[4])
      begin
        sig_valid_next[k] = 1'b1;
        sig_pin_next[k] = hit[3:0];
        used[hit[3:0]] = 1'b1;
      end
    end
    // Reverse map, pin to owning signal
    for (int p = 0; p < NUM_PIN; p++)
    begin
      pin_own_next[p] = 1'b0;
      pin_owner_next[p] = 4'h0;
      for (int k = 0; k < NUM_SIG; k++)
      begin
        if (sig_valid_next[k] && sig_pin_next[k] == 4'(p))
        begin
          pin_own_next[p] = 1'b1;
          pin_owner_next[p] = 4'(k);
        end
      end
    end
  end

  // Pin and signal data paths
  always_comb
  begin
    for (int p = 0; p < NUM_PIN; p++)
    begin
      pin_out_next[p] = gpio_out[p];
      pin_oe_next[p]  = gpio_oe[p];
      if (pin_own_reg[p])
      begin
        pin_out_next[p] = sig_out[pin_owner_reg[p]];
        pin_oe_next[p]  = sig_oe[pin_owner_reg[p]];
      end
    end
    for (int k = 0; k < NUM_SIG; k++)
    begin
      sig_in_next[k] = 1'b1;
      if (sig_valid_reg[k])
      begin
        sig_in_next[k] = pin_in[sig_pin_reg[k]];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sig_valid_reg <= SIG_RESET;
      pin_own_reg   <= PIN_RESET;
      pin_out_reg   <= PIN_RESET;
      pin_oe_reg    <= PIN_RESET;
      sig_in_reg    <= SIG_IN_RESET;
      sig_pin_reg   <= '{default: 4'h0};
      pin_owner_reg <= '{default: 4'h0};
    end
    else
    begin
      sig_valid_reg <= sig_valid_next;
      pin_own_reg   <= pin_own_next;
      pin_out_reg   <= pin_out_next;
      pin_oe_reg    <= pin_oe_next;
      sig_in_reg    <= sig_in_next;
      sig_pin_reg   <= sig_pin_next;
      pin_owner_reg <= pin_owner_next;
    end
  end

  assign pin_out      = pin_out_reg;
  assign pin_oe       = pin_oe_reg;
  assign pin_assigned = pin_own_reg;
  assign sig_in       = sig_in_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence serial_write_s;
    sfr_wr && sfr_addr == ROUTE_EN0_ADDR && sfr_wdata[0] && crossbar_enable;
  endsequence
  sequence still_enabled_s;
    crossbar_enable && !(sfr_wr && sfr_addr == ROUTE_EN0_ADDR);
  endsequence
  serial_pins_a: assert property (
    (serial_write_s ##1 still_enabled_s) |=>
    sig_valid_reg[IDX_SERIAL_TX] && sig_pin_reg[IDX_SERIAL_TX] == 4'h4
    && sig_pin_reg[IDX_SERIAL_RX] == 4'h5)
    else $error("serial pins not placed on P0.4 and P0.5");
  spi_example_a: assert property ((crossbar_enable
    && route_en_reg[SPI_ROUTE_BIT] && spi_four_wire
    && {port1_pin_bypass, port0_pin_bypass} == 16'h0000) |=>
    sig_pin_reg[IDX_SPI_SCK] == 4'h0 && sig_pin_reg[IDX_SPI_MISO] == 4'h1
    && sig_pin_reg[IDX_SPI_MOSI] == 4'h2
    && sig_pin_reg[IDX_SPI_SEL] == 4'h3)
    else $error("SPI pins not on P0.0 to P0.3");
  compare_example_a: assert property ((crossbar_enable
    && route_en_reg == 6'h03 && spi_four_wire
    && compare_output_select == 2'b11
    && {port1_pin_bypass, port0_pin_bypass} == 16'h0000) |=>
    sig_pin_reg[IDX_COMPARE_A] == 4'h6 && sig_pin_reg[IDX_COMPARE_B] == 4'h7
    && sig_pin_reg[IDX_COMPARE_C] == 4'h8)
    else $error("compare outputs not on P0.6, P0.7, P1.0");
  gpio_pass_a: assert property (!$past(srst) |->
    ((pin_out ^ $past(gpio_out)) & ~$past(pin_own_reg)) == 16'h0000)
    else $error("unassigned pin does not follow gpio");
  reserved_zero_a: assert property ($past(sfr_addr) == ROUTE_EN0_ADDR
    |-> sfr_rdata == {2'b00, $past(route_en_reg)})
    else $error("enable register read mismatch");
  async_comp_a: assert property (!route_en_reg[ASYNC_COMPARATOR_BIT]
    |=> !sig_valid_reg[IDX_ASYNC_COMP])
    else $error("async comparator routed while disabled");
  sync_comp_a: assert property (!route_en_reg[COMPARATOR_OUT_BIT]
    |=> !sig_valid_reg[IDX_COMPARATOR])
    else $error("comparator routed while disabled");
  sysclk_gate_a: assert property (!route_en_reg[SYSCLK_OUT_ROUTE_BIT]
    |=> !sig_valid_reg[IDX_SYSCLK_OUT])
    else $error("system clock routed while disabled");
  twowire_pair_a: assert property (sig_valid_reg[IDX_TWOWIRE_DATA]
    || sig_valid_reg[IDX_TWOWIRE_CLK] |-> $past(route_en_reg[2]))
    else $error("two-wire line routed while disabled");
  spi_select_a: assert property (sig_valid_reg[IDX_SPI_SEL]
    |-> $past(spi_four_wire) && sig_valid_reg[IDX_SPI_MOSI])
    else $error("SPI select routed outside four-wire mode");
  serial_gate_a: assert property (!route_en_reg[SERIAL_PORT_ROUTE_BIT]
    |=> sig_valid_reg[1:0] == 2'b00)
    else $error("serial signal routed while disabled");
  compare_count_a: assert property (compare_output_select == 2'b00
    |=> sig_valid_reg[13:11] == 3'b000)
    else $error("compare output routed with select 00");
  skip_respect_a: assert property (sig_valid_reg[IDX_SPI_SCK]
    |-> ($past({port1_pin_bypass, port0_pin_bypass})
    & (16'h0001 << sig_pin_reg[IDX_SPI_SCK])) == 16'h0000
    && PIN_PRESENT[sig_pin_reg[IDX_SPI_SCK]])
    else $error("signal placed on skipped or absent pin");
endmodule
`default_nettype wire

// ==== periph_pin_model.sv ====
// Peripherals and port pins around the crossbar.
// Assumes the bench sets the external level of undriven pins.
`timescale 1ns/100ps
`default_nettype none
module periph_pin_model
(
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext_level,
  output logic      [13:0] sig_out,
  output logic      [13:0] sig_oe,
  output logic      [15:0] pin_in
);
  // Outputs invert the external levels; receive and master-in listen
  assign sig_out = ~ext_level[13:0];
  assign sig_oe  = 14'h3FF5;
  // Driven pin shows its driver, else the external level
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the port crossbar.
// Assumes the crossbar package and the peripheral model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import io_crossbar_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        crossbar_enable = 1'b1;
  logic        spi_four_wire = 1'b0;
  logic [1:0]  compare_output_select = 2'h0;
  logic [7:0]  port0_pin_bypass = 8'h00;
  logic [7:0]  port1_pin_bypass = 8'h00;
  logic [13:0] sig_out;
  logic [13:0] sig_oe;
  logic [13:0] sig_in;
  logic [15:0] gpio_out = 16'h0000;
  logic [15:0] gpio_oe = 16'h0000;
  logic [15:0] ext_level = 16'h0000;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] pin_assigned;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [42:0] tbl [11];

  always #5 clk = ~clk;

  io_crossbar_routing u_dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .crossbar_enable(crossbar_enable), .spi_four_wire(spi_four_wire),
    .compare_output_select(compare_output_select),
    .port0_pin_bypass(port0_pin_bypass), .port1_pin_bypass(port1_pin_bypass),
    .sig_out(sig_out), .sig_oe(sig_oe), .sig_in(sig_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_assigned(pin_assigned));

  periph_pin_model u_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .sig_out(sig_out), .sig_oe(sig_oe),
    .pin_in(pin_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wr = 1'b1;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  task automatic cfg(input logic [7:0] en, input logic fw,
                     input logic [1:0] sel, input logic [7:0] b0,
                     input logic [7:0] b1);
    wr(ROUTE_EN0_ADDR, en);
    spi_four_wire = fw;
    compare_output_select = sel;
    port0_pin_bypass = b0;
    port1_pin_bypass = b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_regs();
    check(pin_assigned, 16'h0000);
    check({2'h0, sig_in}, 16'h3FFF);
    rd(ROUTE_EN0_ADDR, 8'h00);
    wr(ROUTE_EN0_ADDR, 8'hFF);
    rd(ROUTE_EN0_ADDR, 8'h3F);
    wr(8'hE0, 8'h00);
    rd(ROUTE_EN0_ADDR, 8'h3F);
    rd(8'hE0, 8'h00);
  endtask

  task automatic t_example();
    gpio_out = 16'hA5A5;
    gpio_oe = 16'hFFFF;
    cfg(8'h03, 1'b1, 2'h3, 8'h00, 8'h00);
    check(pin_assigned, 16'h01FF);
    check(pin_oe, 16'hFFDD);
    check(pin_out & 16'hFE00, 16'hA400);
    check(pin_out & 16'h01DD, 16'h01DD);
    ext_level = 16'h0000;
    repeat (3) @(negedge clk);
    check({15'h0, sig_in[IDX_SERIAL_RX]}, 16'h0000);
    ext_level = 16'h0020;
    repeat (3) @(negedge clk);
    check({15'h0, sig_in[IDX_SERIAL_RX]}, 16'h0001);
    check(pin_out & 16'h01DD, 16'h01D5);
    ext_level = 16'h0000;
    gpio_out = 16'h0000;
    gpio_oe = 16'h0000;
  endtask

  task automatic t_bits();
    tbl[0]  = {8'h01, 1'b0, 2'h0, 16'h0030, 16'h0010};
    tbl[1]  = {8'h02, 1'b0, 2'h0, 16'h0007, 16'h0005};
    tbl[2]  = {8'h02, 1'b1, 2'h0, 16'h000F, 16'h000D};
    tbl[3]  = {8'h04, 1'b0, 2'h0, 16'h0003, 16'h0003};
    tbl[4]  = {8'h08, 1'b0, 2'h0, 16'h0001, 16'h0001};
    tbl[5]  = {8'h10, 1'b0, 2'h0, 16'h0001, 16'h0001};
    tbl[6]  = {8'h20, 1'b0, 2'h0, 16'h0001, 16'h0001};
    tbl[7]  = {8'h00, 1'b0, 2'h0, 16'h0000, 16'h0000};
    tbl[8]  = {8'h00, 1'b0, 2'h1, 16'h0001, 16'h0001};
    tbl[9]  = {8'h00, 1'b0, 2'h2, 16'h0003, 16'h0003};
    tbl[10] = {8'h00, 1'b0, 2'h3, 16'h0007, 16'h0007};
    for (int i = 0; i < 11; i++)
    begin
      cfg(tbl[i][42:35], tbl[i][34], tbl[i][33:32], 8'h00, 8'h00);
      check(pin_assigned, tbl[i][31:16]);
      check(pin_oe, tbl[i][15:0]);
      check(pin_out, tbl[i][31:16]);
    end
  endtask

  task automatic t_skip();
    cfg(8'h03, 1'b1, 2'h3, 8'h03, 8'h00);
    check(pin_assigned, 16'h07FC);
    cfg(8'h3F, 1'b1, 2'h3, 8'h00, 8'h07);
    check(pin_assigned, 16'h08FF);
  endtask

  task automatic t_reset();
    crossbar_enable = 1'b0;
    repeat (3) @(negedge clk);
    check(pin_assigned, 16'h0000);
    check(pin_oe, 16'h0000);
    crossbar_enable = 1'b1;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check(pin_assigned, 16'h0000);
    check({2'h0, sig_in}, 16'h3FFF);
    check({8'h00, sfr_rdata}, 16'h0000);
    rd(ROUTE_EN0_ADDR, 8'h00);
  endtask

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_regs();
    t_example();
    t_bits();
    t_skip();
    t_reset();
    print_verdict();
  end

  initial
  begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
